// file: rtl/hws_map.svh
/*
  Bus width, strap bit position and reset values of the sideband block.
  Assumes it is included by bare name from design files under rtl/.
*/
`ifndef HWS_MAP_SVH
`define HWS_MAP_SVH

// ROM address/data bus width and the strap bit sampled during reset
`define HWS_ROM_W          8
`define HWS_STRAP_SCLK_BIT 5

// Reset values
`define HWS_RST_FLAG       1'b0
`define HWS_RST_OE         1'b0
`define HWS_RST_LEVEL_HI   1'b1
`define HWS_RST_SCLK_GATE  1'b0

`endif

// file: rtl/hws_pkg.sv
/*
  Types of the sideband block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package hws_pkg;

  // Direction of the hot-swap status pin, one-hot
  typedef enum logic [1:0] {
    HWS_PIN_SENSE = 2'h1,
    HWS_PIN_DRIVE = 2'h2
  } hws_pin_mode_t;

endpackage

// file: rtl/hws_flag.sv
/*
  One sticky event flag: hardware sets, software clears, set wins.
  Assumes set and clear are synchronous to i_clk.
*/
`timescale 1ns/100ps
`default_nettype none
`include "hws_map.svh"

module hws_flag
  import hws_pkg::*;
(
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_reset,
  input  wire logic i_ce,
  // Event and clear
  input  wire logic i_set,
  input  wire logic i_clr,
  // Flag
  output logic      o_flag
);

  logic flag_r;
  logic flag_nxt;

  always_comb begin
    flag_nxt = flag_r;
    if (i_ce) begin
      // An event in the clearing cycle is kept
      flag_nxt = i_set | (flag_r & ~i_clr);
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      flag_r <= `HWS_RST_FLAG;
    end else begin
      flag_r <= flag_nxt;
    end
  end

  assign o_flag = flag_r;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);

  AST_FLAG_SET_WINS: assert property (i_ce && i_set |=> o_flag) // R8
    else $error("flag lost an event that came with its clear");

endmodule
`default_nettype wire

// file: rtl/hws_sideband.sv
/*
  Hot-swap status pin, hot-swap event and wake-event open-drain outputs,
  status-edge interrupt request and the secondary clock output.
  Assumes all inputs synchronous to i_clk; open-drain lines pulled up
  outside; i_reset held for at least one i_clk edge.
*/
// Operation
// R1: Primary signals sampled and launched on rising edge
// R2: Secondary inputs sampled on a rising edge
// R3: Secondary clock output runs at primary frequency
// R4: Stop secondary clock by bit or strap
// R5: Sensing status pin gives ejector switch state
// R6: Driving status pin controls the LED
// R7: Assert hot-swap event on insertion or removal
// R8: Release hot-swap event when event bit cleared
// R9: Assert wake only on low input, support, enable
// R10: Release wake when status or enable clears
// R11: Rising wake input edge may request interrupt A
// R12: Event and wake outputs are open-drain
`timescale 1ns/100ps
`default_nettype none
`include "hws_map.svh"

module hws_sideband
  import hws_pkg::*;
(
  // Clock, reset, enable
  input  wire logic                 i_clk,
  input  wire logic                 i_reset,
  input  wire logic                 i_ce,
  // Strap bus, sampled during reset
  input  wire logic [`HWS_ROM_W-1:0] i_rom_address_data_bus,
  // Secondary clock control and output
  input  wire logic                 i_sclk_disable,
  output logic                      o_sec_clk,
  // Hot-swap status pin
  input  wire hws_pin_mode_t        i_hs_mode,
  input  wire logic                 i_hs_led_on,
  input  wire logic                 i_hs_stat,
  output logic                      o_hs_stat,
  output logic                      o_hs_stat_oe,
  output logic                      o_hs_ejector_open,
  // Hot-swap event
  input  wire logic                 i_enum_en,
  input  wire logic                 i_ins_clr,
  input  wire logic                 i_rem_clr,
  output logic                      o_ins_event,
  output logic                      o_rem_event,
  output logic                      o_enum,
  output logic                      o_enum_oe,
  // Wake event
  input  wire logic                 i_sec_wake_n,
  input  wire logic                 i_pm_state_ok,
  input  wire logic                 i_wake_en,
  input  wire logic                 i_wake_sts_clr,
  input  wire logic                 i_status_int_en,
  output logic                      o_wake_sts,
  output logic                      o_wake,
  output logic                      o_wake_oe,
  output logic                      o_status_int
);

  ////////////////////////////////////////////////////////////////////////
  // Input sampling and output registers

  logic stat_r;
  logic stat_prev_r;
  logic swake_r;
  logic swake_prev_r;
  logic stat_oe_r;
  logic led_r;
  logic enum_oe_r;
  logic wake_oe_r;
  logic int_r;
  logic stat_nxt;
  logic stat_prev_nxt;
  logic swake_nxt;
  logic swake_prev_nxt;
  logic stat_oe_nxt;
  logic led_nxt;
  logic enum_oe_nxt;
  logic wake_oe_nxt;
  logic int_nxt;
  logic ins_set;
  logic rem_set;
  logic ins_q;
  logic rem_q;
  logic wsts_q;
  logic sensing;

  assign sensing = (i_hs_mode == HWS_PIN_SENSE);
  // Pin high reads ejector open; never sampled while we still drive it
  assign ins_set = sensing & stat_prev_r & ~stat_r; // R5
  assign rem_set = sensing & ~stat_prev_r & stat_r; // R5

  always_comb begin
    stat_nxt       = stat_r;
    stat_prev_nxt  = stat_prev_r;
    swake_nxt      = swake_r;
    swake_prev_nxt = swake_prev_r;
    stat_oe_nxt    = stat_oe_r;
    led_nxt        = led_r;
    enum_oe_nxt    = enum_oe_r;
    wake_oe_nxt    = wake_oe_r;
    int_nxt        = int_r;
    if (i_ce) begin
      stat_nxt       = (sensing & ~stat_oe_r) ? i_hs_stat : stat_r; // R1 R5
      stat_prev_nxt  = stat_r;
      swake_nxt      = i_sec_wake_n; // R2
      swake_prev_nxt = swake_r;
      stat_oe_nxt    = (i_hs_mode == HWS_PIN_DRIVE); // R6
      led_nxt        = i_hs_led_on; // R6
      enum_oe_nxt    = i_enum_en & (ins_q | rem_q); // R7 R8
      // Assert needs all four terms; hold needs status and enable
      wake_oe_nxt    = i_wake_en & wsts_q &
                       ((~swake_r & i_pm_state_ok) | wake_oe_r); // R9 R10
      int_nxt        = i_status_int_en & swake_r & ~swake_prev_r; // R11
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      stat_r       <= `HWS_RST_LEVEL_HI;
      stat_prev_r  <= `HWS_RST_LEVEL_HI;
      swake_r      <= `HWS_RST_LEVEL_HI;
      swake_prev_r <= `HWS_RST_LEVEL_HI;
      stat_oe_r    <= `HWS_RST_OE;
      led_r        <= `HWS_RST_FLAG;
      enum_oe_r    <= `HWS_RST_OE;
      wake_oe_r    <= `HWS_RST_OE;
      int_r        <= `HWS_RST_FLAG;
    end else begin
      stat_r       <= stat_nxt;
      stat_prev_r  <= stat_prev_nxt;
      swake_r      <= swake_nxt;
      swake_prev_r <= swake_prev_nxt;
      stat_oe_r    <= stat_oe_nxt;
      led_r        <= led_nxt;
      enum_oe_r    <= enum_oe_nxt;
      wake_oe_r    <= wake_oe_nxt;
      int_r        <= int_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Sticky event bits

  hws_flag u_ins (
    .i_clk   (i_clk),
    .i_reset (i_reset),
    .i_ce    (i_ce),
    .i_set   (ins_set),
    .i_clr   (i_ins_clr),
    .o_flag  (ins_q)
  );

  hws_flag u_rem (
    .i_clk   (i_clk),
    .i_reset (i_reset),
    .i_ce    (i_ce),
    .i_set   (rem_set),
    .i_clr   (i_rem_clr),
    .o_flag  (rem_q)
  );

  hws_flag u_wsts (
    .i_clk   (i_clk),
    .i_reset (i_reset),
    .i_ce    (i_ce),
    .i_set   (~swake_r),
    .i_clr   (i_wake_sts_clr),
    .o_flag  (wsts_q)
  );

  ////////////////////////////////////////////////////////////////////////
  // Secondary clock

  // Strap caught by a plain clocked flop while reset is high, so that
  // reset itself never loads a pin value
  logic strap_off_r;
  logic strap_off_nxt;
  logic sclk_req_r;
  logic sclk_req_nxt;
  logic sclk_gate_r;
  logic sclk_gate_nxt;

  always_comb begin
    strap_off_nxt = strap_off_r;
    if (i_reset) begin
      strap_off_nxt = ~i_rom_address_data_bus[`HWS_STRAP_SCLK_BIT]; // R4
    end
  end

  always_ff @(posedge i_clk) begin
    strap_off_r <= strap_off_nxt;
  end

  always_comb begin
    sclk_req_nxt  = sclk_req_r;
    sclk_gate_nxt = sclk_req_r;
    if (i_ce) begin
      sclk_req_nxt = ~i_sclk_disable & ~strap_off_r; // R4
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      sclk_req_r <= `HWS_RST_SCLK_GATE;
    end else begin
      sclk_req_r <= sclk_req_nxt;
    end
  end

  // Copies a settled request while the clock is low: no glitch, no race
  always_ff @(negedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      sclk_gate_r <= `HWS_RST_SCLK_GATE;
    end else begin
      sclk_gate_r <= sclk_gate_nxt;
    end
  end

  assign o_sec_clk = i_clk & sclk_gate_r; // R3

  ////////////////////////////////////////////////////////////////////////
  // Outputs

  assign o_hs_stat         = led_r;
  assign o_hs_stat_oe      = stat_oe_r;
  assign o_hs_ejector_open = stat_r;
  assign o_ins_event       = ins_q;
  assign o_rem_event       = rem_q;
  assign o_enum            = 1'b0; // R12
  assign o_enum_oe         = enum_oe_r; // R12
  assign o_wake            = 1'b0; // R12
  assign o_wake_oe         = wake_oe_r; // R12
  assign o_wake_sts        = wsts_q;
  assign o_status_int      = int_r;

  ////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);

  AST_ENUM_SET: assert property ( // R7
    i_ce && i_enum_en && (ins_q || rem_q) |=> o_enum_oe)
    else $error("hot-swap event not asserted for a pending event");

  AST_ENUM_REL: assert property ( // R8
    i_ce && !ins_q && !rem_q |=> !o_enum_oe)
    else $error("hot-swap event held with no event bit");

  AST_WAKE_SET: assert property ( // R9
    i_ce && i_wake_en && wsts_q && i_pm_state_ok && !swake_r
    |=> o_wake_oe)
    else $error("wake output not asserted");

  AST_WAKE_ONLY: assert property ( // R9
    i_ce && !o_wake_oe && (swake_r || !i_pm_state_ok) |=> !o_wake_oe)
    else $error("wake output asserted without its conditions");

  AST_WAKE_REL: assert property ( // R10
    i_ce && (!i_wake_en || !wsts_q) |=> !o_wake_oe)
    else $error("wake output held after status or enable cleared");

  AST_STAT_DRIVE: assert property ( // R6
    i_ce && i_hs_mode == HWS_PIN_DRIVE && i_hs_led_on
    |=> o_hs_stat_oe && o_hs_stat)
    else $error("status pin not driving the LED");

  AST_INS_EDGE: assert property ( // R5
    i_ce && sensing && stat_prev_r && !stat_r |=> o_ins_event)
    else $error("ejector close not recorded");

  AST_INT_EDGE: assert property ( // R11
    i_ce && i_status_int_en && swake_r && !swake_prev_r
    |=> o_status_int ##1 (!o_status_int || !i_ce || swake_prev_r))
    else $error("status edge interrupt wrong");

  AST_SCLK_OFF: assert property ( // R4
    i_ce && (i_sclk_disable || strap_off_r) |=> !sclk_gate_r)
    else $error("secondary clock not stopped");

  AST_OPEN_DRAIN: assert property (!o_enum && !o_wake) // R12
    else $error("open-drain line driven high");

  COV_ENUM: cover property (i_ce && ins_set ##1 o_ins_event ##1 o_enum_oe);
  COV_WAKE: cover property (!o_wake_oe ##1 o_wake_oe ##[1:20] !o_wake_oe);
  COV_INT:  cover property (o_status_int);
  COV_SCLK: cover property (sclk_gate_r ##1 !sclk_gate_r);

endmodule
`default_nettype wire

// file: tb/hws_card_model.sv
/*
  Card and host side of the sideband block: ejector switch, pull-ups.
  Assumes the bench commands the switch and the subsystem wake request.
*/
`timescale 1ns/100ps
`default_nettype none

module hws_card_model (
  // Bench commands
  input  wire logic i_ejector_open,
  input  wire logic i_wake_req,
  // Device pins
  input  wire logic i_stat_drv,
  input  wire logic i_stat_oe,
  input  wire logic i_enum_oe,
  input  wire logic i_wake_oe,
  // Resolved wires
  output logic      o_stat_pin,
  output logic      o_enum_line,
  output logic      o_wake_line,
  output logic      o_sec_wake_n
);
  // The switch only wins while the device does not drive the pin
  assign o_stat_pin   = i_stat_oe ? i_stat_drv : i_ejector_open;
  // Open-drain lines float to the pull-up level when released
  assign o_enum_line  = i_enum_oe ? 1'b0 : 1'b1;
  assign o_wake_line  = i_wake_oe ? 1'b0 : 1'b1;
  assign o_sec_wake_n = !i_wake_req;
endmodule
`default_nettype wire

// file: tb/tb_hws_sideband.sv
/*
  Self-checking bench of the sideband block.
  Assumes one 25 MHz clock; inputs change at falling edges.
*/
`timescale 1ns/100ps
`default_nettype none

module tb_hws_sideband;
  import hws_pkg::*;
  logic          i_clk, i_reset, i_ce, i_sclk_disable, i_hs_led_on;
  logic          i_enum_en, i_ins_clr, i_rem_clr, i_pm_state_ok;
  logic          i_wake_en, i_wake_sts_clr, i_status_int_en, ej, wreq;
  logic [7:0]    i_rom_address_data_bus;
  hws_pin_mode_t i_hs_mode;
  logic          o_sec_clk, o_hs_stat, o_hs_stat_oe, o_hs_ejector_open;
  logic          o_ins_event, o_rem_event, o_enum, o_enum_oe, o_wake_sts;
  logic          o_wake, o_wake_oe, o_status_int;
  logic          i_hs_stat, enum_ln, wake_ln, i_sec_wake_n;
  int            fails, total_checks, sclk_cnt;

  hws_sideband DUT (.i_clk, .i_reset, .i_ce, .i_rom_address_data_bus,
    .i_sclk_disable, .o_sec_clk, .i_hs_mode, .i_hs_led_on, .i_hs_stat,
    .o_hs_stat, .o_hs_stat_oe, .o_hs_ejector_open, .i_enum_en, .i_ins_clr,
    .i_rem_clr, .o_ins_event, .o_rem_event, .o_enum, .o_enum_oe,
    .i_sec_wake_n, .i_pm_state_ok, .i_wake_en, .i_wake_sts_clr,
    .i_status_int_en, .o_wake_sts, .o_wake, .o_wake_oe, .o_status_int);

  hws_card_model PARTNER (.i_ejector_open(ej), .i_wake_req(wreq),
    .i_stat_drv(o_hs_stat), .i_stat_oe(o_hs_stat_oe), .i_enum_oe(o_enum_oe),
    .i_wake_oe(o_wake_oe), .o_stat_pin(i_hs_stat), .o_enum_line(enum_ln),
    .o_wake_line(wake_ln), .o_sec_wake_n(i_sec_wake_n));

  initial begin
    i_clk = 1'b0;
    forever #20 i_clk = !i_clk;
  end

  always @(posedge o_sec_clk) sclk_cnt++;

  //////////////////////////////////////////////////////////////////////////
  task automatic check(input string nm, input logic e, input logic g);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %s expected %b seen %b", nm, e, g);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge i_clk);
  endtask

  task automatic do_reset();
    i_reset = 1'b1;
    cyc(3);
    i_reset = 1'b0;
    cyc(2);
  endtask

  //////////////////////////////////////////////////////////////////////////
  task automatic t_hot_swap();
    ej = 1'b0;
    cyc(4);
    check("ejector_open", 1'b0, o_hs_ejector_open);
    check("ins_event", 1'b1, o_ins_event);
    check("enum_line", 1'b0, enum_ln);
    check("enum_drive", 1'b0, o_enum);
    i_ins_clr = 1'b1;
    cyc(1);
    i_ins_clr = 1'b0;
    cyc(2);
    check("enum_released", 1'b1, enum_ln);
    ej = 1'b1;
    cyc(4);
    check("rem_event", 1'b1, o_rem_event);
    check("enum_oe_rem", 1'b1, o_enum_oe);
    i_rem_clr = 1'b1;
    cyc(1);
    i_rem_clr = 1'b0;
    cyc(2);
    check("enum_oe_cleared", 1'b0, o_enum_oe);
  endtask

  task automatic t_led();
    i_hs_mode   = HWS_PIN_DRIVE;
    i_hs_led_on = 1'b0;
    ej          = 1'b0;
    cyc(3);
    check("stat_oe", 1'b1, o_hs_stat_oe);
    check("stat_pin_low", 1'b0, i_hs_stat);
    check("no_event_drive", 1'b0, o_ins_event);
    i_hs_led_on = 1'b1;
    cyc(3);
    check("stat_pin_high", 1'b1, i_hs_stat);
    i_hs_mode = HWS_PIN_SENSE;
    ej        = 1'b1;
    cyc(3);
    check("stat_oe_off", 1'b0, o_hs_stat_oe);
  endtask

  task automatic t_wake();
    wreq = 1'b1;
    cyc(4);
    check("wake_no_pm", 1'b1, wake_ln);
    check("wake_sts_set", 1'b1, o_wake_sts);
    wreq = 1'b0;
    cyc(1);
    i_wake_sts_clr = 1'b1;
    cyc(1);
    i_wake_sts_clr = 1'b0;
    check("wake_sts_clr", 1'b0, o_wake_sts);
    i_pm_state_ok = 1'b1;
    wreq          = 1'b1;
    cyc(4);
    check("wake_line", 1'b0, wake_ln);
    check("wake_drive", 1'b0, o_wake);
    wreq = 1'b0;
    cyc(3);
    check("wake_held", 1'b1, o_wake_oe);
    i_wake_sts_clr = 1'b1;
    cyc(1);
    i_wake_sts_clr = 1'b0;
    cyc(1);
    check("wake_off_sts", 1'b0, o_wake_oe);
    wreq = 1'b1;
    cyc(4);
    check("wake_again", 1'b0, wake_ln);
    wreq      = 1'b0;
    i_wake_en = 1'b0;
    cyc(2);
    check("wake_off_en", 1'b0, o_wake_oe);
  endtask

  task automatic t_status_int();
    i_status_int_en = 1'b1;
    wreq            = 1'b1;
    cyc(3);
    wreq = 1'b0;
    cyc(2);
    check("int_pulse", 1'b1, o_status_int);
    cyc(1);
    check("int_end", 1'b0, o_status_int);
  endtask

  task automatic t_sclk();
    sclk_cnt = 0;
    cyc(10);
    check("sclk_runs", 1'b1, sclk_cnt == 10);
    i_sclk_disable = 1'b1;
    cyc(2);
    sclk_cnt = 0;
    cyc(5);
    check("sclk_bit_stop", 1'b1, sclk_cnt == 0);
    i_sclk_disable         = 1'b0;
    i_rom_address_data_bus = 8'hDF;
    do_reset();
    i_rom_address_data_bus = 8'hFF;
    sclk_cnt = 0;
    cyc(5);
    check("sclk_strap_stop", 1'b1, sclk_cnt == 0);
    do_reset();
    sclk_cnt = 0;
    cyc(5);
    check("sclk_strap_run", 1'b1, sclk_cnt == 5);
  endtask

  //////////////////////////////////////////////////////////////////////////
  initial begin
    {i_reset, i_sclk_disable, i_hs_led_on, i_ins_clr, i_rem_clr} = 5'h00;
    {i_pm_state_ok, i_wake_sts_clr, i_status_int_en, wreq} = 4'h0;
    {i_ce, i_enum_en, i_wake_en, ej} = 4'hF;
    i_rom_address_data_bus = 8'hFF;
    i_hs_mode              = HWS_PIN_SENSE;
    fails                  = 0;
    total_checks           = 0;
    do_reset();
    check("enum_reset", 1'b1, enum_ln);
    t_hot_swap();
    t_led();
    t_wake();
    t_status_int();
    t_sclk();
    finish_test();
  end

  initial begin
    #40000;
    fails++;
    finish_test();
  end
endmodule
`default_nettype wire
